// file: logic/sac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic conv_enable_in,
  input wire sac_pkg::sac_cfg_type cfg_in,
  input wire logic go_set_in,
  input wire logic go_clear_in,
  input wire logic done_flag_clear_in,
  input wire logic rc_tick_in,
  input wire logic comparator_in,
  output logic go_flag_out,
  output logic conversion_done_flag_out,
  output logic wake_request_out,
  output sac_pkg::sac_result_type result_out,
  output logic [3:0] channel_select_out,
  output logic channel_valid_out,
  output logic ref_external_out,
  output logic sample_hold_out,
  output logic [`SAC_RES_BITS-1:0] dac_trial_out
);

  sac_pkg::sac_state_type state_r, state_nxt;
  logic [`SAC_RES_BITS-1:0] sar_r, sar_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [1:0] abort_cnt_r, abort_cnt_nxt;
  logic flag_r, flag_nxt;
  logic wake_r, wake_nxt;
  sac_pkg::sac_result_type res_r, res_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic chan_ok_r, chan_ok_nxt;
  logic ref_r, ref_nxt;
  logic bp_tick;
  logic done_now;

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  sac_prescaler u_presc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clk_sel_in(cfg_in.clk_sel),
    .rc_tick_in(rc_tick_in),
    .bp_tick_out(bp_tick)
  );

  // ----------------------------------------------------------------
  // Routing of input and reference
  // ----------------------------------------------------------------
  always_comb begin
    chan_nxt = cfg_in.channel;
    // Reserved codes leave the sample-and-hold unconnected
    chan_ok_nxt = (cfg_in.channel <= `SAC_CH_FIXED_REF);
    ref_nxt = cfg_in.ref_external;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    sar_nxt = sar_r;
    idx_nxt = idx_r;
    abort_cnt_nxt = abort_cnt_r;
    done_now = 1'b0;
    unique case (state_r)
      sac_pkg::SAC_IDLE: begin
        if (go_set_in && conv_enable_in) begin
          state_nxt = sac_pkg::SAC_HOLD;
        end
      end
      sac_pkg::SAC_HOLD: begin
        // First period samples the input; ten more resolve the bits
        if (bp_tick) begin
          state_nxt = sac_pkg::SAC_CONV;
          sar_nxt = `SAC_SAR_FIRST;
          idx_nxt = 4'h9;
        end
      end
      sac_pkg::SAC_CONV: begin
        if (bp_tick) begin
          sar_nxt[idx_r] = comparator_in;
          if (idx_r == 4'h0) begin
            state_nxt = sac_pkg::SAC_DONE;
          end else begin
            sar_nxt[idx_r - 4'h1] = 1'b1;
            idx_nxt = idx_r - 4'h1;
          end
        end
      end
      sac_pkg::SAC_DONE: begin
        done_now = 1'b1;
        state_nxt = sac_pkg::SAC_IDLE;
      end
      sac_pkg::SAC_ABORT: begin
        // Two periods of quiet before a new start is honoured
        if (bp_tick) begin
          abort_cnt_nxt = abort_cnt_r + 2'h1;
          if (abort_cnt_r == 2'(`SAC_ABORT_PERIODS - 1)) begin
            state_nxt = sac_pkg::SAC_IDLE;
          end
        end
      end
      default: state_nxt = sac_pkg::SAC_IDLE;
    endcase
    if ((state_r == sac_pkg::SAC_HOLD || state_r == sac_pkg::SAC_CONV)
        && go_clear_in) begin
      state_nxt = sac_pkg::SAC_ABORT;
      abort_cnt_nxt = 2'h0;
    end
    // Turning the converter off drops any conversion without delay, except one already in SAC_DONE
    if (!conv_enable_in && state_r != sac_pkg::SAC_DONE) begin
      state_nxt = sac_pkg::SAC_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Result and completion flag
  // ----------------------------------------------------------------
  always_comb begin
    res_nxt = res_r;
    if (done_now) begin
      if (cfg_in.justify_right) begin
        res_nxt.high = {6'h00, sar_r[9:8]};
        res_nxt.low = sar_r[7:0];
      end else begin
        res_nxt.high = sar_r[9:2];
        res_nxt.low = {sar_r[1:0], 6'h00};
      end
    end
    // A completion in the clearing cycle is kept
    flag_nxt = done_now | (flag_r & ~done_flag_clear_in);
    wake_nxt = done_now;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= sac_pkg::SAC_IDLE;
      sar_r <= `SAC_RST_SAR;
      idx_r <= 4'h0;
      abort_cnt_r <= 2'h0;
      flag_r <= 1'b0;
      wake_r <= 1'b0;
      res_r <= {`SAC_RST_RESULT, `SAC_RST_RESULT};
      chan_r <= `SAC_RST_CHAN;
      chan_ok_r <= 1'b1;
      ref_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sar_r <= sar_nxt;
      idx_r <= idx_nxt;
      abort_cnt_r <= abort_cnt_nxt;
      flag_r <= flag_nxt;
      wake_r <= wake_nxt;
      res_r <= res_nxt;
      chan_r <= chan_nxt;
      chan_ok_r <= chan_ok_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign go_flag_out = (state_r == sac_pkg::SAC_HOLD) ||
                       (state_r == sac_pkg::SAC_CONV) ||
                       (state_r == sac_pkg::SAC_DONE);
  assign conversion_done_flag_out = flag_r;
  assign wake_request_out = wake_r;
  assign result_out = res_r;
  assign channel_select_out = chan_r;
  assign channel_valid_out = chan_ok_r;
  assign ref_external_out = ref_r;
  assign sample_hold_out = (state_r == sac_pkg::SAC_CONV) ||
                           (state_r == sac_pkg::SAC_DONE);
  assign dac_trial_out = sar_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] bp_seen_r;
  logic [6:0] gap_r;
  logic sel_same_r;

  always_ff @(posedge clk_in) begin
    if (rst_in || state_r == sac_pkg::SAC_IDLE) begin
      bp_seen_r <= 5'h00;
    end else if (bp_tick && bp_seen_r != 5'h1f) begin
      bp_seen_r <= bp_seen_r + 5'h01;
    end
    if (rst_in || bp_tick) begin
      gap_r <= 7'h01;
    end else if (gap_r != 7'h7f) begin
      gap_r <= gap_r + 7'h01;
    end
    if (rst_in || $changed(cfg_in.clk_sel)) begin
      sel_same_r <= 1'b0;
    end else if (bp_tick) begin
      sel_same_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_done_clears_go: assert property (done_now |=> !go_flag_out)
    else $error("go flag still set after completion");
  a_done_sets_flag: assert property (done_now |=> conversion_done_flag_out
                                     && wake_request_out)
    else $error("done flag or wake not raised");
  a_eleven_periods: assert property (done_now |->
                                     bp_seen_r == 5'(`SAC_BP_PER_CONV))
    else $error("conversion length is not eleven periods");
  a_right_justify: assert property (done_now && cfg_in.justify_right |=>
    result_out == {6'h00, $past(sar_r)})
    else $error("right justified result wrong");
  a_left_justify: assert property (done_now && !cfg_in.justify_right |=>
    result_out == {$past(sar_r), 6'h00})
    else $error("left justified result wrong");
  a_div2_rate: assert property (bp_tick && sel_same_r &&
    cfg_in.clk_sel == `SAC_CS_DIV2 |-> gap_r == 7'h02)
    else $error("divide by two period wrong");
  a_div64_rate: assert property (bp_tick && sel_same_r &&
    cfg_in.clk_sel == `SAC_CS_DIV64 |-> gap_r == 7'h40)
    else $error("divide by sixty-four period wrong");
  a_rc_follows: assert property (cfg_in.clk_sel[1:0] == `SAC_CS_RC_LOW &&
    $past(cfg_in.clk_sel[1:0]) == `SAC_CS_RC_LOW |->
    bp_tick == $past(rc_tick_in))
    else $error("RC clock not passed through");
  a_chan_routes: assert property (##1 channel_select_out ==
    $past(cfg_in.channel) && ref_external_out ==
    $past(cfg_in.ref_external))
    else $error("channel or reference not routed");
  a_reserved_chan: assert property (cfg_in.channel > `SAC_CH_FIXED_REF
                                    |=> !channel_valid_out)
    else $error("reserved channel connected");
  a_abort_keeps: assert property (state_r == sac_pkg::SAC_ABORT
                                  |=> $stable(result_out))
    else $error("abort altered result");
  // A hold must begin with the midscale trial already on the converter
  a_hold_during: assert property ($rose(sample_hold_out) |->
                                  dac_trial_out == `SAC_SAR_FIRST)
    else $error("hold began without midscale trial");

  c_full_conv: cover property (done_now && cfg_in.justify_right);
  c_abort: cover property (state_r == sac_pkg::SAC_ABORT ##1
                           state_r == sac_pkg::SAC_IDLE);
  c_rc_conv: cover property (done_now &&
                             cfg_in.clk_sel[1:0] == `SAC_CS_RC_LOW);
  c_clear_race: cover property (done_now && done_flag_clear_in);

endmodule
`default_nettype wire

// file: logic/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// ----------------------------------------------------------------
// Widths and conversion lengths
// ----------------------------------------------------------------
`define SAC_RES_BITS 10
`define SAC_BP_PER_CONV 11
`define SAC_ABORT_PERIODS 2
`define SAC_DIV_CNT_BITS 6

// ----------------------------------------------------------------
// Conversion clock select codes
// ----------------------------------------------------------------
`define SAC_CS_DIV2 3'h0
`define SAC_CS_DIV4 3'h4
`define SAC_CS_DIV8 3'h1
`define SAC_CS_DIV16 3'h5
`define SAC_CS_DIV32 3'h2
`define SAC_CS_DIV64 3'h6
`define SAC_CS_RC_LOW 2'h3

// ----------------------------------------------------------------
// Channel codes
// ----------------------------------------------------------------
`define SAC_CH_LAST_PIN 4'hb
`define SAC_CH_CMP_REF 4'hc
`define SAC_CH_FIXED_REF 4'hd

// ----------------------------------------------------------------
// Reset values and first trial
// ----------------------------------------------------------------
`define SAC_RST_RESULT 8'h00
`define SAC_RST_SAR 10'h000
`define SAC_SAR_FIRST 10'h200
`define SAC_RST_CHAN 4'h0

`endif

// file: logic/sac_pkg.sv
package sac_pkg;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b000,
    SAC_HOLD = 3'b001,
    SAC_CONV = 3'b010,
    SAC_DONE = 3'b011,
    SAC_ABORT = 3'b100
  } sac_state_type;

  typedef struct packed {
    logic justify_right;
    logic ref_external;
    logic [3:0] channel;
    logic [2:0] clk_sel;
  } sac_cfg_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sac_result_type;

endpackage

// file: logic/sac_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_prescaler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] clk_sel_in,
  input wire logic rc_tick_in,
  output logic bp_tick_out
);

  logic [`SAC_DIV_CNT_BITS-1:0] cnt_r;
  logic [`SAC_DIV_CNT_BITS-1:0] cnt_nxt;
  logic [`SAC_DIV_CNT_BITS-1:0] last;
  logic tick_r;
  logic tick_nxt;

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  always_comb begin
    unique case (clk_sel_in)
      `SAC_CS_DIV2: last = 6'h01;
      `SAC_CS_DIV4: last = 6'h03;
      `SAC_CS_DIV8: last = 6'h07;
      `SAC_CS_DIV16: last = 6'h0f;
      `SAC_CS_DIV32: last = 6'h1f;
      `SAC_CS_DIV64: last = 6'h3f;
      default: last = 6'h01;
    endcase
    // Wrap on >= so a smaller ratio chosen mid-count takes effect at once
    cnt_nxt = (cnt_r >= last) ? 6'h00 : cnt_r + 6'h01;
    if (clk_sel_in[1:0] == `SAC_CS_RC_LOW) begin
      tick_nxt = rc_tick_in;
    end else begin
      tick_nxt = (cnt_r >= last);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bp_tick_out = tick_r;

endmodule
`default_nettype wire

// file: test/sac_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

// ----------------------------------------------------------------
// Analog side: input mux, sample-and-hold, comparator, RC ticks
// ----------------------------------------------------------------
module sac_analog_model #(
  parameter int RC_DIV = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`SAC_RES_BITS-1:0] level_in,
  input wire logic [3:0] channel_in,
  input wire logic ref_external_in,
  input wire logic sample_hold_in,
  input wire logic [`SAC_RES_BITS-1:0] dac_trial_in,
  output logic comparator_out,
  output logic rc_tick_out
);
  logic [`SAC_RES_BITS-1:0] held_r;
  logic [`SAC_RES_BITS-1:0] live;
  logic tog_r;
  logic [3:0] rc_cnt_r;

  // With the internal reference each channel gives the held level a distinct value; the external reference halves it for every channel
  // Every pin is taken as already set to analog input
  assign live = ref_external_in ? {1'b0, level_in[9:1]} :
                level_in ^ {6'h00, channel_in};
  always_ff @(posedge clk_in) begin
    if (!sample_hold_in) begin
      held_r <= live;
    end
    tog_r <= rst_in ? 1'b0 : ~tog_r;
    rc_cnt_r <= (rst_in || rc_cnt_r == 4'(RC_DIV - 1)) ? 4'h0 :
                rc_cnt_r + 4'h1;
  end
  // Outside a hold the decision is meaningless, so it keeps toggling
  assign comparator_out = sample_hold_in ? (held_r >= dac_trial_in) :
                          tog_r;
  assign rc_tick_out = (rc_cnt_r == 4'h0);
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  localparam int RC_DIV = 5;
  logic clk_in = 1'b0, rst_in = 1'b1, conv_enable_in = 1'b1;
  logic go_set_in = 1'b0, go_clear_in = 1'b0, done_flag_clear_in = 1'b0;
  logic rc_tick, comparator, go_flag, done_flag, wake, ch_valid, ref_ext;
  logic sample_hold;
  logic [3:0] ch_sel;
  logic [9:0] trial;
  logic [9:0] level = 10'h000;
  sac_pkg::sac_cfg_type cfg = '0;
  sac_pkg::sac_result_type result, last_r, want;
  sac_pkg::sac_result_type exp_q[$];
  int fails = 0, n_tests = 0, cyc = 0;

  sac_top i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .conv_enable_in(conv_enable_in), .cfg_in(cfg), .go_set_in(go_set_in),
    .go_clear_in(go_clear_in), .done_flag_clear_in(done_flag_clear_in),
    .rc_tick_in(rc_tick), .comparator_in(comparator),
    .go_flag_out(go_flag), .conversion_done_flag_out(done_flag),
    .wake_request_out(wake), .result_out(result),
    .channel_select_out(ch_sel), .channel_valid_out(ch_valid),
    .ref_external_out(ref_ext), .sample_hold_out(sample_hold),
    .dac_trial_out(trial));
  sac_analog_model #(.RC_DIV(RC_DIV)) i_model (.clk_in(clk_in),
    .rst_in(rst_in), .level_in(level), .channel_in(ch_sel),
    .ref_external_in(ref_ext), .sample_hold_in(sample_hold),
    .dac_trial_in(trial), .comparator_out(comparator),
    .rc_tick_out(rc_tick));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Checking side: result pops the oldest note at each completion
  // ----------------------------------------------------------------
  always @(negedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
    if (wake === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(wake, 1'b0)
      end else begin
        want = exp_q.pop_front();
        `CHK(result, want)
        `CHK(done_flag, 1'b1)
        `CHK(go_flag, 1'b0)
      end
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cycles(int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cycles(1);
    s = 1'b0;
  endtask

  function automatic int div_of(logic [2:0] cs);
    if (cs[1:0] == 2'h3) return RC_DIV;
    return 2 << {cs[1:0], cs[2]};
  endfunction

  // ----------------------------------------------------------------
  // One conversion: configure, settle, start, time it, clear flag
  // ----------------------------------------------------------------
  task automatic conv(logic [2:0] cs, logic [3:0] ch, logic rx, logic jr);
    int d, n;
    logic [9:0] v;
    cfg = '{justify_right: jr, ref_external: rx, channel: ch, clk_sel: cs};
    level = 10'($urandom % 1024);
    cycles(4);
    v = rx ? {1'b0, level[9:1]} : level ^ {6'h00, ch};
    last_r = jr ? '{high: {6'h00, v[9:8]}, low: v[7:0]} :
                  '{high: v[9:2], low: {v[1:0], 6'h00}};
    exp_q.push_back(last_r);
    pulse(go_set_in);
    `CHK(go_flag, 1'b1)
    d = 0;
    n = div_of(cs);
    while (go_flag === 1'b1 && d < 2000) begin
      d++;
      cycles(1);
    end
    `CHK(d >= 10 * n + 1 && d <= 11 * n + 2, 1'b1)
    pulse(done_flag_clear_in);
    `CHK(done_flag, 1'b0)
  endtask

  initial begin
    void'($urandom(32'h2ac5));
    cycles(12);
    rst_in = 1'b0;
    cycles(1);
    `CHK({go_flag, done_flag, wake, ch_valid}, 4'h1)
    `CHK(result, 16'h0000)
    $display("test reset done");
    for (int ch = 0; ch < 16; ch++) begin
      cfg.channel = 4'(ch);
      cfg.ref_external = ch[0];
      cycles(2);
      `CHK(ch_sel, 4'(ch))
      `CHK(ch_valid, ch < 14)
      `CHK(ref_ext, ch[0])
    end
    $display("test channels done");
    for (int cs = 0; cs < 8; cs++) begin
      conv(3'(cs), 4'(cs + 6), cs[0], cs[1]);
    end
    conv(3'h0, 4'h0, 1'b0, 1'b1);
    conv(3'h4, 4'hb, 1'b0, 1'b0);
    $display("test conversions done");
    cfg.clk_sel = `SAC_CS_DIV16;
    pulse(go_set_in);
    cycles(60);
    pulse(go_clear_in);
    cycles(40);
    `CHK({go_flag, done_flag}, 2'h0)
    `CHK(result, last_r)
    conv(3'h5, 4'h3, 1'b1, 1'b1);
    $display("test abort done");
    pulse(go_set_in);
    cycles(20);
    conv_enable_in = 1'b0;
    cycles(2);
    `CHK(go_flag, 1'b0)
    `CHK(result, last_r)
    pulse(go_set_in);
    cycles(2);
    `CHK(go_flag, 1'b0)
    conv_enable_in = 1'b1;
    cycles(2);
    conv(3'h1, 4'h7, 1'b0, 1'b0);
    $display("test enable done");
    close_out();
  end
endmodule
`default_nettype wire
